// *** rtl/flash_lock_pkg.sv ***
// shared constants for the flash lock-bit host controller
// assumes a 100 MHz pclk and an APB register port with 32-bit data
package flash_lock_pkg;

  // ----------------------------------------------------------------
  // clock and bus timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;  // pclk period
  localparam int T_STROBE_NS   = 50;  // least write or read strobe width
  localparam int STROBE_CYC    =      // least time, rounded up
    (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL   = 12'h000;  // op, pins, go
  localparam logic [11:0] OFS_STAT   = 12'h004;  // controller state
  localparam logic [11:0] OFS_ADDR   = 12'h008;  // block address
  localparam logic [11:0] OFS_CODE   = 12'h00C;  // status pin code

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_OP_LSB  = 0;   // op select, 3 bits
  localparam int CTRL_OP_W    = 3;
  localparam int CTRL_WP_BIT  = 4;   // write-protect level
  localparam int CTRL_RP_BIT  = 5;   // reset/power-down level
  localparam int CTRL_GO_BIT  = 8;   // start pulse, reads zero

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int STAT_BUSY_BIT = 0;  // sequence running
  localparam int STAT_REDO_BIT = 1;  // clear lock-bits must repeat
  localparam int STAT_REF_BIT  = 2;  // last go refused
  localparam int STAT_PIN_BIT  = 3;  // status pin level
  localparam int STAT_SR_LSB   = 8;  // last device status byte

  // ----------------------------------------------------------------
  // device status byte bits
  // ----------------------------------------------------------------
  localparam int SR_READY_BIT   = 7;  // status_ready_bit
  localparam int SR_CLR_ERR_BIT = 5;  // erase_clear_lock_error_bit
  localparam int SR_SET_ERR_BIT = 4;  // program_set_lock_error_bit
  localparam int SR_SUPPLY_BIT  = 3;  // supply_low_bit
  localparam int SR_PROT_BIT    = 1;  // device_protect_bit

  // ----------------------------------------------------------------
  // operations and status pin codes
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_SET_LOCK   = 3'h0;
  localparam logic [2:0] OP_CLEAR_LOCK = 3'h1;
  localparam logic [2:0] OP_PIN_CONFIG = 3'h2;
  localparam logic [2:0] OP_CLEAR_SR   = 3'h3;

  localparam logic [1:0] PIN_LEVEL     = 2'h0;  // ready/busy level mode
  localparam logic [1:0] PIN_PULSE_ERS = 2'h1;  // pulse on erase events
  localparam logic [1:0] PIN_PULSE_WR  = 2'h2;  // pulse on write events
  localparam logic [1:0] PIN_PULSE_ALL = 2'h3;  // pulse on all events

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,  // waiting for go
    S_FIRST = 6'b000010,  // setup or single command write
    S_SECND = 6'b000100,  // confirm or code write
    S_POLL  = 6'b001000,  // status read until ready
    S_CLRSR = 6'b010000,  // clear status after an error
    S_WAIT  = 6'b100000   // bus cycle finishing
  } seq_state_e;

endpackage : flash_lock_pkg

// *** rtl/flash_bus_cycle.sv ***
// one asynchronous write or read cycle on the flash command bus
// assumes the device samples address and data on the rising write strobe
module flash_bus_cycle
  import flash_lock_pkg::*;
#(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // request and answer
  input  wire logic              start,
  input  wire logic              is_read,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic                   done,
  output logic      [DATA_W-1:0] rdata,
  // flash pins
  output logic      [ADDR_W-1:0] flash_addr,
  output logic      [DATA_W-1:0] flash_dq_out,
  output logic                   flash_dq_oe_n,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n
);

  localparam int CNT_W = 8;

  // refuse a strobe count the 8-bit counter cannot hold
  if (STROBE_CYC < 1 || STROBE_CYC > 250) begin : g_bad_strobe
    $error("flash_bus_cycle: strobe count out of range");
  end

  // ----------------------------------------------------------------
  // phase: 0 idle, 1 setup, 2 strobe, 3 hold
  // ----------------------------------------------------------------
  logic [1:0]       phase_reg;  // cycle phase
  logic [CNT_W-1:0] cnt_reg;    // strobe cycles left
  logic             rd_reg;     // cycle is a read

  // cycle sequencing and pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg     <= 2'h0;
      cnt_reg       <= '0;
      rd_reg        <= 1'b0;
      done          <= 1'b0;
      rdata         <= '0;
      flash_addr    <= '0;
      flash_dq_out  <= '0;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
    end else begin
      done <= 1'b0;
      case (phase_reg)
        2'h0: begin  // accept request, present address
          if (start) begin
            phase_reg     <= 2'h1;
            rd_reg        <= is_read;
            flash_addr    <= addr;
            flash_dq_out  <= wdata;
            flash_dq_oe_n <= is_read;
            flash_ce_n    <= 1'b0;
          end
        end
        2'h1: begin  // open the strobe
          phase_reg  <= 2'h2;
          cnt_reg    <= CNT_W'(STROBE_CYC - 1);
          flash_we_n <= rd_reg;
          flash_oe_n <= !rd_reg;
        end
        2'h2: begin  // hold strobe, then close it
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end else begin
            phase_reg  <= 2'h3;
            rdata      <= flash_dq_in;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
          end
        end
        default: begin  // data hold, release bus
          phase_reg     <= 2'h0;
          done          <= 1'b1;
          flash_ce_n    <= 1'b1;
          flash_dq_oe_n <= 1'b1;
        end
      endcase
    end
  end

endmodule : flash_bus_cycle

// *** rtl/flash_lock_host.sv ***
// host controller for flash block lock bits and status pin setup
// assumes an APB master on the register side and a flash on the pins
//
// Notes on behaviour
// - set lock: setup write, then confirm write
// - host polls ready bit for completion
// - host checks error bit, clears status
// - clear lock: setup write, then confirm write
// - aborted clear must be repeated by host
// - pin config: command, code; reset high
module flash_lock_host
  import flash_lock_pkg::*;
#(
  parameter int         ADDR_W        = 21,
  parameter int         DATA_W        = 16,
  parameter logic [7:0] CMD_LOCK_SET  = 8'h11,  // opcode, plain default
  parameter logic [7:0] CMD_LOCK_CLR  = 8'h22,  // opcode, plain default
  parameter logic [7:0] CMD_CONFIRM   = 8'h33,  // opcode, plain default
  parameter logic [7:0] CMD_PIN_CFG   = 8'h44,  // opcode, plain default
  parameter logic [7:0] CMD_CLEAR_SR  = 8'h55   // opcode, plain default
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // flash command bus
  output logic      [ADDR_W-1:0] flash_addr,
  output logic      [DATA_W-1:0] flash_dq_out,
  output logic                   flash_dq_oe_n,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n,
  // flash control pins
  output logic                   write_protect,
  output logic                   reset_powerdown_n,
  input  wire logic              status_output_pin
);

  // refuse widths the register map cannot carry
  if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 8 || DATA_W > 32)
  begin : g_bad_width
    $error("flash_lock_host: unsupported width");
  end

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  seq_state_e        state_reg;    // sequencer state
  seq_state_e        after_reg;    // state after the bus cycle
  logic [2:0]        op_reg;       // selected operation
  logic [ADDR_W-1:0] addr_reg;     // block address
  logic [1:0]        code_reg;     // status pin configuration code
  logic [7:0]        sr_reg;       // last device status byte
  logic              redo_reg;     // clear lock-bits must repeat
  logic              ref_reg;      // last go refused
  logic              pin_reg;      // status pin, sampled
  logic              cyc_start;    // bus cycle request
  logic              cyc_read;     // bus cycle is a read
  logic [7:0]        cyc_cmd;      // command byte for the cycle
  logic              cyc_done;     // bus cycle finished
  logic [DATA_W-1:0] cyc_rdata;    // data read by the cycle
  logic              apb_wr;       // write completes this edge
  logic              go;           // software start request
  logic              redo_go;      // automatic repeat of clear

  assign apb_wr  = psel && penable && pready && pwrite;
  assign go      = apb_wr && paddr == OFS_CTRL && pwdata[CTRL_GO_BIT];
  assign redo_go = redo_reg && reset_powerdown_n
                   && state_reg == S_IDLE && !go;

  // ----------------------------------------------------------------
  // apb slave: one wait state, registered answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && penable && !pready) begin
        case (paddr)
          OFS_CTRL: begin  // pin levels and op readback
            prdata[CTRL_OP_LSB +: CTRL_OP_W] <= op_reg;
            prdata[CTRL_WP_BIT] <= write_protect;
            prdata[CTRL_RP_BIT] <= reset_powerdown_n;
          end
          OFS_STAT: begin  // controller and device state
            prdata[STAT_BUSY_BIT] <= state_reg != S_IDLE;
            prdata[STAT_REDO_BIT] <= redo_reg;
            prdata[STAT_REF_BIT]  <= ref_reg;
            prdata[STAT_PIN_BIT]  <= pin_reg;
            prdata[STAT_SR_LSB +: 8] <= sr_reg;
          end
          OFS_ADDR: prdata[ADDR_W-1:0] <= addr_reg;
          OFS_CODE: prdata[1:0] <= code_reg;
          default:  pslverr <= 1'b1;  // unmapped
        endcase
      end
    end
  end

  // software writable fields; op and address frozen while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg            <= OP_SET_LOCK;
      addr_reg          <= '0;
      code_reg          <= PIN_LEVEL;
      write_protect     <= 1'b0;
      reset_powerdown_n <= 1'b0;
    end else if (apb_wr) begin
      case (paddr)
        OFS_CTRL: begin
          write_protect     <= pwdata[CTRL_WP_BIT];
          reset_powerdown_n <= pwdata[CTRL_RP_BIT];
          if (state_reg == S_IDLE)
            op_reg <= pwdata[CTRL_OP_LSB +: CTRL_OP_W];
        end
        OFS_ADDR: begin
          if (state_reg == S_IDLE)
            addr_reg <= pwdata[ADDR_W-1:0];
        end
        OFS_CODE: code_reg <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // status pin sample, level mode low means busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_reg <= 1'b1;
    else          pin_reg <= status_output_pin;
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      after_reg <= S_IDLE;
      cyc_start <= 1'b0;
      cyc_read  <= 1'b0;
      cyc_cmd   <= '0;
      ref_reg   <= 1'b0;
      sr_reg    <= '0;
    end else begin
      cyc_start <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (go || redo_go) begin
            ref_reg <= 1'b0;
            if (!reset_powerdown_n) begin
              ref_reg <= 1'b1;
            end else begin
              state_reg <= S_FIRST;
            end
          end
        end
        S_FIRST: begin  // setup write, address of the block
          cyc_start <= 1'b1;
          cyc_read  <= 1'b0;
          case (redo_go ? OP_CLEAR_LOCK : op_reg)
            OP_SET_LOCK:   cyc_cmd <= CMD_LOCK_SET;
            OP_CLEAR_LOCK: cyc_cmd <= CMD_LOCK_CLR;
            OP_PIN_CONFIG: cyc_cmd <= CMD_PIN_CFG;
            default:       cyc_cmd <= CMD_CLEAR_SR;
          endcase
          after_reg <= (op_reg == OP_CLEAR_SR) ? S_IDLE : S_SECND;
          state_reg <= S_WAIT;
        end
        S_SECND: begin  // confirm or configuration code
          cyc_start <= 1'b1;
          cyc_read  <= 1'b0;
          if (op_reg == OP_PIN_CONFIG) begin
            cyc_cmd   <= {6'h00, code_reg};
            after_reg <= S_IDLE;
          end else begin
            cyc_cmd   <= CMD_CONFIRM;
            after_reg <= S_POLL;
          end
          state_reg <= S_WAIT;
        end
        S_POLL: begin  // reads now return status
          cyc_start <= 1'b1;
          cyc_read  <= 1'b1;
          after_reg <= S_POLL;
          state_reg <= S_WAIT;
        end
        S_CLRSR: begin  // error seen, clear device status
          cyc_start <= 1'b1;
          cyc_read  <= 1'b0;
          cyc_cmd   <= CMD_CLEAR_SR;
          after_reg <= S_IDLE;
          state_reg <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            state_reg <= after_reg;
            if (cyc_read) begin
              sr_reg <= cyc_rdata[7:0];
              if (!cyc_rdata[SR_READY_BIT])
                state_reg <= S_POLL;
              else if (cyc_rdata[SR_SET_ERR_BIT]
                       || cyc_rdata[SR_CLR_ERR_BIT])
                state_reg <= S_CLRSR;
              else
                state_reg <= S_IDLE;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
      if (!reset_powerdown_n && state_reg != S_IDLE
          && !(state_reg == S_WAIT && !cyc_done))
        state_reg <= S_IDLE;  // device reset aborts the sequence
    end
  end

  // clear aborted by reset: remember to repeat it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      redo_reg <= 1'b0;
    end else if (!reset_powerdown_n && state_reg != S_IDLE
                 && op_reg == OP_CLEAR_LOCK) begin
      redo_reg <= 1'b1;
    end else if (state_reg == S_WAIT && cyc_done && cyc_read
                 && cyc_rdata[SR_READY_BIT]) begin
      redo_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // flash bus cycle engine
  // ----------------------------------------------------------------
  flash_bus_cycle #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_cycle (
    .pclk          (pclk),
    .presetn       (presetn),
    .start         (cyc_start),
    .is_read       (cyc_read),
    .addr          (addr_reg),
    .wdata         (DATA_W'(cyc_cmd)),
    .done          (cyc_done),
    .rdata         (cyc_rdata),
    .flash_addr    (flash_addr),
    .flash_dq_out  (flash_dq_out),
    .flash_dq_oe_n (flash_dq_oe_n),
    .flash_dq_in   (flash_dq_in),
    .flash_ce_n    (flash_ce_n),
    .flash_we_n    (flash_we_n),
    .flash_oe_n    (flash_oe_n)
  );

endmodule : flash_lock_host

// *** tb/flash_lock_host_sva.sv ***
// checker for the flash lock host: apb timing and flash strobes
// assumes binding to flash_lock_host, sees its ports only
module flash_lock_host_chk #(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16
) (
  // clock, reset and apb answer
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // flash command bus
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic              flash_dq_oe_n,
  input wire logic              flash_ce_n,
  input wire logic              flash_we_n,
  input wire logic              flash_oe_n,
  input wire logic              status_output_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_rdy_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  wr_width_a: assert property ($fell(flash_we_n) |->
    !flash_we_n [*5] ##1 flash_we_n) else $error("write strobe width");
  rd_width_a: assert property ($fell(flash_oe_n) |->
    !flash_oe_n [*5] ##1 flash_oe_n) else $error("read strobe width");
  ce_lead_a: assert property ($fell(flash_we_n) |->
    $past(flash_ce_n) == 1'b0) else $error("chip select late");
  ce_trail_a: assert property ($rose(flash_we_n) |->
    !flash_ce_n ##1 flash_ce_n) else $error("chip select release");
  cmd_hold_a: assert property (!flash_we_n && $past(flash_we_n) == 1'b0
    |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("command moved in strobe");
  dq_drive_a: assert property (!flash_we_n |-> !flash_dq_oe_n)
    else $error("dq not driven");
  no_fight_a: assert property (!flash_oe_n |-> flash_dq_oe_n)
    else $error("dq driven in read");

  // main scenarios reached
  cover property (pready && pslverr);
  cover property ($fell(flash_oe_n));
  cover property ($fell(status_output_pin));
endmodule : flash_lock_host_chk

bind flash_lock_host flash_lock_host_chk #(
  .ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.pclk, .presetn, .psel,
  .penable, .prdata, .pready, .pslverr, .flash_addr, .flash_dq_out,
  .flash_dq_oe_n, .flash_ce_n, .flash_we_n, .flash_oe_n,
  .status_output_pin);

// *** tb/flash_dev_model.sv ***
// behavioural flash device: lock bits, status byte, status pin
// assumes the host strobes are sampled on pclk; pin has a pull-up
module flash_dev_model #(
  parameter logic [7:0] C_SET = 8'h11,  // arbitrary, matches host
  parameter logic [7:0] C_CLR = 8'h22,
  parameter logic [7:0] C_CNF = 8'h33,
  parameter logic [7:0] C_PIN = 8'h44,
  parameter logic [7:0] C_CSR = 8'h55
) (
  // clock for timing only
  input  wire logic        pclk,
  // pins from the host
  input  wire logic [20:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic        write_protect,
  input  wire logic        reset_powerdown_n,
  // bench controls
  input  wire logic        supply_low,
  input  wire logic [31:0] busy_len,
  // pins to the host
  output logic      [15:0] flash_dq_in,
  output logic             status_output_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  sr;             // status byte
  logic [7:0]  lock = 8'h00;   // one lock bit per block
  logic [7:0]  pend;           // first write awaiting second
  logic [1:0]  pin_mode;       // status pin mode
  logic        we_q = 1'b1;    // strobe edge finder
  logic        was_set;        // running op was a set
  logic        pulse_n = 1'b1; // pulse output
  logic [15:0] junk = 16'hA5A5;
  int          busy;
  wire  [7:0]  cmd = flash_dq_out[7:0];
  wire  [2:0]  blk = flash_addr[20:18];

  // released bus shows a changing pattern
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? {8'h00, sr} : junk;
  assign status_output_pin = (pin_mode == 2'h0) ? (busy == 0) : pulse_n;

  // command decoder and write state machine
  always @(posedge pclk) begin
    we_q    <= flash_we_n;
    junk    <= ~junk;
    pulse_n <= 1'b1;
    if (!reset_powerdown_n) begin
      if (busy != 0) lock <= 8'hFF;  // aborted op leaves junk
      sr       <= 8'h80;
      pend     <= 8'h00;
      pin_mode <= 2'h0;
      busy     <= 0;
    end else if (busy != 0) begin
      busy <= busy - 1;
      if (busy == 1) begin
        sr[7] <= 1'b1;
        if (pin_mode == 2'h3 || pin_mode == (was_set ? 2'h2 : 2'h1))
          pulse_n <= 1'b0;
      end
    end else if (!we_q && flash_we_n && !flash_ce_n) begin
      pend <= 8'h00;
      if (pend == C_SET || pend == C_CLR) begin
        if (cmd != C_CNF) sr <= sr | 8'h30;
        else if (!write_protect)
          sr <= sr | ((pend == C_SET) ? 8'h12 : 8'h22);
        else if (pend == C_CLR && supply_low) sr <= sr | 8'h28;
        else begin
          sr[7]   <= 1'b0;
          busy    <= busy_len;
          was_set <= (pend == C_SET);
          if (pend == C_SET) lock[blk] <= 1'b1;
          else lock <= 8'h00;
        end
      end else if (pend == C_PIN) pin_mode <= cmd[1:0];
      else if (cmd == C_CSR) sr <= 8'h80;
      else pend <= cmd;
    end
  end
endmodule : flash_dev_model

// *** tb/test_flash_lock_host.sv ***
// self-checking bench for the flash lock host controller
// assumes the device model on the flash pins and an apb master here
module test_flash_lock_host;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_lock_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [20:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic        flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n;
  logic        write_protect, reset_powerdown_n, status_output_pin;
  logic        supply_low;
  int          failures, n_checks, busy_len, lows, n;

  flash_lock_host DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .flash_addr, .flash_dq_out,
    .flash_dq_oe_n, .flash_dq_in, .flash_ce_n, .flash_we_n, .flash_oe_n,
    .write_protect, .reset_powerdown_n, .status_output_pin);
  flash_dev_model dev (.pclk, .flash_addr, .flash_dq_out, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .write_protect, .reset_powerdown_n,
    .supply_low, .busy_len, .flash_dq_in, .status_output_pin);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // count cycles with the status pin low
  always @(posedge pclk) if (status_output_pin === 1'b0) lows <= lows + 1;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(32'(pslverr), 32'(a > OFS_CODE));
  endtask : apb

  function automatic logic [31:0] ctl(logic [2:0] op, logic wp, logic rp,
                                     logic g);
    return {23'h0, g, 2'h0, rp, wp, 1'b0, op};
  endfunction : ctl

  // start an operation and poll until the controller is idle
  task automatic run(input logic [2:0] op, input logic wp);
    apb(1'b1, OFS_CTRL, ctl(op, wp, 1'b1, 1'b0));
    apb(1'b1, OFS_CTRL, ctl(op, wp, 1'b1, 1'b1));
    do begin
      apb(1'b0, OFS_STAT, 32'h0);
    end while (rq[1:0] !== 2'b00 || dev.busy != 0);
  endtask : run

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  initial begin
    #400_000;
    failures++;
    final_report;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, supply_low} = '0;
    {paddr, pwdata, failures, n_checks, lows} = '0;
    busy_len = 3;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rq & 32'h7, 32'h0);
    chk(32'(reset_powerdown_n), 32'h0);
    apb(1'b0, OFS_CODE, 32'h0);
    chk(rq, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(rq, 32'h0);
    apb(1'b1, OFS_CTRL, ctl(OP_SET_LOCK, 1'b1, 1'b0, 1'b1));
    apb(1'b0, OFS_STAT, 32'h0);
    chk(32'(rq[STAT_REF_BIT]), 32'h1);
    $display("test reset done");
    apb(1'b1, OFS_ADDR, 32'h140000);
    run(OP_SET_LOCK, 1'b1);
    chk(32'(rq[15:8]), 32'h80);
    apb(1'b1, OFS_ADDR, 32'h080000);
    run(OP_SET_LOCK, 1'b1);
    chk(32'(dev.lock), 32'h24);
    apb(1'b1, OFS_ADDR, 32'h0C0000);
    run(OP_SET_LOCK, 1'b0);
    chk(32'(rq[15:8]), 32'h92);
    chk(32'(dev.sr), 32'h80);
    supply_low <= 1'b1;
    run(OP_CLEAR_LOCK, 1'b1);
    chk(32'(rq[15:8]), 32'hA8);
    supply_low <= 1'b0;
    run(OP_CLEAR_LOCK, 1'b0);
    chk(32'(rq[15:8]), 32'hA2);
    chk(32'(dev.lock), 32'h24);
    chk(32'(dev.sr), 32'h80);
    $display("test lock errors done");
    busy_len <= 40;
    apb(1'b1, OFS_CTRL, ctl(OP_CLEAR_LOCK, 1'b1, 1'b1, 1'b0));
    apb(1'b1, OFS_CTRL, ctl(OP_CLEAR_LOCK, 1'b1, 1'b1, 1'b1));
    while (dev.busy == 0) begin
      @(posedge pclk);
    end
    apb(1'b1, OFS_CTRL, ctl(OP_CLEAR_LOCK, 1'b1, 1'b0, 1'b0));
    do begin
      apb(1'b0, OFS_STAT, 32'h0);
    end while (rq[STAT_BUSY_BIT] !== 1'b0);
    chk(32'(rq[STAT_REDO_BIT]), 32'h1);
    run(OP_CLEAR_LOCK, 1'b1);
    chk(32'(dev.lock), 32'h0);
    $display("test aborted clear done");
    busy_len <= 3;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, OFS_CODE, 32'(c));
      run(OP_PIN_CONFIG, 1'b1);
      chk(32'(dev.pin_mode), 32'(c));
      n = lows;
      run(OP_SET_LOCK, 1'b1);
      chk(32'(lows != n), 32'(c != 1));
      n = lows;
      run(OP_CLEAR_LOCK, 1'b1);
      chk(32'(lows != n), 32'(c != 2));
    end
    apb(1'b1, OFS_CTRL, ctl(OP_SET_LOCK, 1'b1, 1'b0, 1'b0));
    repeat (2) @(posedge pclk);
    chk(32'(dev.pin_mode), 32'h0);
    $display("test status pin done");
    final_report;
  end
endmodule : test_flash_lock_host
